// *** rtl/afe_aux_control.v ***
/*
  Auxiliary front-end control: excitation current routing, automatic
  current-source rotation with averaging, eight multiplexed digital I/O
  pins and the test-voltage DAC decode and routing.
  Assumes one 25 MHz clock, synchronous active-high reset, a classic
  Wishbone master, and a converter core that pulses conv_valid_i with a
  signed result and obeys conv_hold_o while the front end settles.
*/
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "afe_aux_control_map.vh"

// Functional notes
// - each current source routes to one of eleven pins
// - rotation swaps sources after every conversion
// - first rotated-sequence result withheld
// - publish half of current plus previous
// - settle builtin plus four-bit extra after swap
// - eight upper pins usable as digital I/O
// - connect bit one attaches digital function
// - direction zero output, one input
// - data drives outputs, reads inputs, outputs zero
// - separate positive/negative DACs feed matching muxes
// - enable bits route DACs to pins seven/eight
// - decode codes as binary steps around mid-supply
module afe_aux_control #(
  parameter integer DATA_W     = 32,                     // converter result width
  parameter integer SETTLE_CYC = `BUILTIN_SETTLE_CYC,    // built-in settling count
  parameter integer UNIT_CYC   = `EXTRA_DELAY_UNIT_CYC   // cycles per extra delay step
) (
  input  wire              clk_i,              // 25 MHz clock
  input  wire              rst_i,              // synchronous reset, active high
  input  wire [7:0]        adr_i,              // wishbone byte address
  input  wire [31:0]       dat_i,              // wishbone write data
  output reg  [31:0]       dat_o,              // wishbone read data
  input  wire              we_i,               // wishbone write enable
  input  wire [3:0]        sel_i,              // wishbone byte selects
  input  wire              cyc_i,              // wishbone cycle
  input  wire              stb_i,              // wishbone strobe
  output reg               ack_o,              // wishbone acknowledge
  input  wire              conv_valid_i,       // one-cycle pulse: conversion done
  input  wire [DATA_W-1:0] conv_data_i,        // signed conversion value
  input  wire              conv_restart_i,     // pulse: conversions restarted
  output wire              conv_hold_o,        // hold converter while settling
  output reg               result_valid_o,     // one-cycle pulse: result published
  output reg  [DATA_W-1:0] result_data_o,      // published signed result
  output reg  [10:0]       current_a_pin_o,    // one-hot pin of excitation_current_a
  output reg  [10:0]       current_b_pin_o,    // one-hot pin of excitation_current_b
  output wire              reference_on_o,     // internal reference enable
  output wire [7:0]        io_digital_o,       // pin attached to digital function
  output wire [7:0]        io_pin_out_o,       // digital pin drive value
  output wire [7:0]        io_pin_oe_o,        // digital pin output enable
  input  wire [7:0]        io_pin_in_i,        // digital pin level
  output reg  [9:0]        test_pos_level_o,   // positive dac offset, 1/640 supply
  output reg  [9:0]        test_neg_level_o,   // negative dac offset, 1/640 supply
  output wire              test_pos_pin_enable_o, // positive dac to analog_input_seven
  output wire              test_neg_pin_enable_o  // negative dac to analog_input_eight
);

  // ***************************************************************
  // helper functions
  // ***************************************************************

  // pin number to one-hot select; numbers past the last pin leave it open
  function [10:0] pin_onehot;
    input [3:0] pin;
    begin
      if (pin < `ANALOG_PIN_COUNT) begin
        pin_onehot = 11'h001 << pin;
      end else begin
        pin_onehot = 11'h000;
      end
    end
  endfunction

  // dac code to signed offset from mid-supply in 1/640 supply units;
  // step k is 2^(k-1) units, upper nibble one mirrors below mid-supply
  function [9:0] test_voltage_dac_level;
    input [4:0] code;
    reg   [9:0] mag;
    begin
      mag = 10'h000;
      if (code[3:0] != 4'h0 && code[3:0] <= `TEST_VOLTAGE_DAC_MAX_STEP) begin
        mag = 10'h001 << (code[3:0] - 4'h1);
      end
      if (code[4] == `TEST_VOLTAGE_DAC_NEG_NIBBLE) begin
        test_voltage_dac_level = ~mag + 10'h001;
      end else begin
        test_voltage_dac_level = mag;
      end
    end
  endfunction

  // byte-lane merge for wishbone writes
  function [7:0] lane;
    input [7:0] old_v;
    input [7:0] new_v;
    input       en;
    begin
      lane = en ? new_v : old_v;
    end
  endfunction

  // ***************************************************************
  // register file
  // ***************************************************************
  reg        rotate_r;        // automatic rotation enabled
  reg        ref_on_r;        // internal reference on
  reg [3:0]  delay_r;         // extra settling code
  reg [3:0]  route_a_r;       // pin number of source a
  reg [3:0]  route_b_r;       // pin number of source b
  reg [7:0]  io_connect_r;    // io_connect_reg
  reg [7:0]  io_direction_r;  // io_direction_reg
  reg [7:0]  io_data_r;       // io_data_reg, drive values
  reg [4:0]  test_voltage_dac_p_code_r;   // test_dac_positive code
  reg [4:0]  test_voltage_dac_n_code_r;   // test_dac_negative code
  reg        test_voltage_dac_p_en_r;     // test_pos_pin_enable
  reg        test_voltage_dac_n_en_r;     // test_neg_pin_enable
  reg        sw_restart_r;    // one-cycle restart from software

  wire       bus_req  = cyc_i & stb_i & ~ack_o;  // new request, ack not yet given
  wire       bus_wr   = bus_req & we_i;          // write takes effect with ack
  wire       rot_chg  = bus_wr & sel_i[0] & (adr_i == `OFS_MODE_CONFIG_REG0) &
                        (dat_i[`MODE_ROTATE_BIT] != rotate_r);

  // writes land in the cycle ack rises; unmapped writes are dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      rotate_r       <= 1'b0;
      ref_on_r       <= 1'b0;
      delay_r        <= 4'h0;
      route_a_r      <= `RST_ROUTE_PIN;
      route_b_r      <= `RST_ROUTE_PIN;
      io_connect_r   <= `RST_IO_BYTE;
      io_direction_r <= `RST_IO_DIRECTION;
      io_data_r      <= `RST_IO_BYTE;
      test_voltage_dac_p_code_r  <= `RST_TEST_VOLTAGE_DAC_CODE;
      test_voltage_dac_n_code_r  <= `RST_TEST_VOLTAGE_DAC_CODE;
      test_voltage_dac_p_en_r    <= 1'b0;
      test_voltage_dac_n_en_r    <= 1'b0;
      sw_restart_r   <= 1'b0;
    end else begin
      sw_restart_r <= 1'b0;
      if (bus_wr) begin
        case (adr_i)
          `OFS_MODE_CONFIG_REG0: begin
            if (sel_i[0]) begin
              rotate_r     <= dat_i[`MODE_ROTATE_BIT];
              sw_restart_r <= dat_i[`MODE_RESTART_BIT];  // self-clearing
              ref_on_r     <= dat_i[`MODE_REF_ON_BIT];
              delay_r      <= dat_i[`MODE_DELAY_MSB:`MODE_DELAY_LSB];
            end
          end
          `OFS_CURRENT_ROUTE: begin
            if (sel_i[0]) begin
              route_a_r <= dat_i[`ROUTE_A_MSB:`ROUTE_A_LSB];
            end
            if (sel_i[1]) begin
              route_b_r <= dat_i[`ROUTE_B_MSB:`ROUTE_B_LSB];
            end
          end
          `OFS_IO_CONNECT_REG: begin
            io_connect_r <= lane(io_connect_r, dat_i[7:0], sel_i[0]);
          end
          `OFS_IO_DIRECTION_REG: begin
            io_direction_r <= lane(io_direction_r, dat_i[7:0], sel_i[0]);
          end
          `OFS_IO_DATA_REG: begin
            io_data_r <= lane(io_data_r, dat_i[7:0], sel_i[0]);
          end
          `OFS_TEST_DAC_POSITIVE: begin
            if (sel_i[0]) begin
              test_voltage_dac_p_code_r <= dat_i[`TEST_VOLTAGE_DAC_CODE_MSB:0];
              test_voltage_dac_p_en_r   <= dat_i[`TEST_VOLTAGE_DAC_PIN_EN_BIT];
            end
          end
          `OFS_TEST_DAC_NEGATIVE: begin
            if (sel_i[0]) begin
              test_voltage_dac_n_code_r <= dat_i[`TEST_VOLTAGE_DAC_CODE_MSB:0];
              test_voltage_dac_n_en_r   <= dat_i[`TEST_VOLTAGE_DAC_PIN_EN_BIT];
            end
          end
          default: begin
            sw_restart_r <= 1'b0;  // unmapped or read-only: ignored
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // rotation sequencer
  // ***************************************************************
  reg              have_prev_r;  // a conversion of this sequence is held
  reg              swapped_r;    // sources currently exchanged
  reg [DATA_W-1:0] prev_r;       // previous conversion value
  reg [15:0]       settle_r;     // settling cycles remaining
  reg              fresh_r;      // unread result in RESULT register

  wire             restart  = conv_restart_i | sw_restart_r | rot_chg;
  wire [DATA_W:0]  pair_sum = {conv_data_i[DATA_W-1], conv_data_i} +
                              {prev_r[DATA_W-1], prev_r};
  wire [15:0]      settle_total = SETTLE_CYC[15:0] + delay_r * UNIT_CYC[11:0];

  // converter is held off while the swapped connections settle
  assign conv_hold_o = (settle_r != 16'h0000);

  // one conversion consumed per pulse; a pulse during settling is discarded
  always @(posedge clk_i) begin
    if (rst_i) begin
      have_prev_r    <= 1'b0;
      swapped_r      <= 1'b0;
      prev_r         <= {DATA_W{1'b0}};
      settle_r       <= 16'h0000;
      result_valid_o <= 1'b0;
      result_data_o  <= {DATA_W{1'b0}};
    end else begin
      result_valid_o <= 1'b0;
      if (settle_r != 16'h0000) begin
        settle_r <= settle_r - 16'h0001;
      end
      if (restart) begin
        // sequence begins again from the normal assignment
        have_prev_r <= 1'b0;
        swapped_r   <= 1'b0;
        settle_r    <= 16'h0000;
      end else if (conv_valid_i && settle_r == 16'h0000) begin
        if (!rotate_r) begin
          result_valid_o <= 1'b1;
          result_data_o  <= conv_data_i;
        end else begin
          prev_r      <= conv_data_i;
          have_prev_r <= 1'b1;
          swapped_r   <= ~swapped_r;
          settle_r    <= settle_total;
          if (have_prev_r) begin
            result_valid_o <= 1'b1;
            result_data_o  <= pair_sum[DATA_W:1];
          end
          // first conversion of a sequence publishes nothing
        end
      end
    end
  end

  // ***************************************************************
  // current source routing
  // ***************************************************************

  // exchange pin assignments while swapped; both reach any of 11 pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      current_a_pin_o <= 11'h000;
      current_b_pin_o <= 11'h000;
    end else if (swapped_r) begin
      current_a_pin_o <= pin_onehot(route_b_r);
      current_b_pin_o <= pin_onehot(route_a_r);
    end else begin
      current_a_pin_o <= pin_onehot(route_a_r);
      current_b_pin_o <= pin_onehot(route_b_r);
    end
  end

  // the sources need the reference; software sets it first
  assign reference_on_o = ref_on_r;

  // ***************************************************************
  // digital I/O pins (analog_input_four .. common_analog_input)
  // ***************************************************************
  assign io_digital_o = io_connect_r;
  assign io_pin_oe_o  = io_connect_r & ~io_direction_r;
  assign io_pin_out_o = io_data_r & io_pin_oe_o;

  // ***************************************************************
  // test DAC
  // ***************************************************************

  // both levels feed the matching input muxes of both converters
  always @(posedge clk_i) begin
    if (rst_i) begin
      test_pos_level_o <= 10'h000;
      test_neg_level_o <= 10'h000;
    end else begin
      test_pos_level_o <= test_voltage_dac_level(test_voltage_dac_p_code_r);
      test_neg_level_o <= test_voltage_dac_level(test_voltage_dac_n_code_r);
    end
  end

  assign test_pos_pin_enable_o = test_voltage_dac_p_en_r;
  assign test_neg_pin_enable_o = test_voltage_dac_n_en_r;

  // ***************************************************************
  // wishbone read path and acknowledge
  // ***************************************************************

  // tracks whether the latest published result was read yet
  always @(posedge clk_i) begin
    if (rst_i) begin
      fresh_r <= 1'b0;
    end else if (result_valid_o) begin
      fresh_r <= 1'b1;  // new result beats a same-cycle read
    end else if (bus_req && !we_i && adr_i == `OFS_RESULT) begin
      fresh_r <= 1'b0;
    end
  end

  // single wait-free answer: ack and data one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      dat_o <= 32'h00000000;
      if (bus_req && !we_i) begin
        case (adr_i)
          `OFS_MODE_CONFIG_REG0:
            dat_o <= {24'h000000, delay_r, 1'b0, ref_on_r, 1'b0, rotate_r};
          `OFS_CURRENT_ROUTE:
            dat_o <= {20'h00000, route_b_r, 4'h0, route_a_r};
          `OFS_IO_CONNECT_REG:
            dat_o <= {24'h000000, io_connect_r};
          `OFS_IO_DIRECTION_REG:
            dat_o <= {24'h000000, io_direction_r};
          `OFS_IO_DATA_REG:
            // input levels; output-configured bits read zero
            dat_o <= {24'h000000, io_pin_in_i & io_direction_r};
          `OFS_TEST_DAC_POSITIVE:
            dat_o <= {24'h000000, test_voltage_dac_p_en_r, 2'b00, test_voltage_dac_p_code_r};
          `OFS_TEST_DAC_NEGATIVE:
            dat_o <= {24'h000000, test_voltage_dac_n_en_r, 2'b00, test_voltage_dac_n_code_r};
          `OFS_STATUS:
            dat_o <= {28'h0000000, fresh_r, conv_hold_o, swapped_r, have_prev_r};
          `OFS_RESULT:
            dat_o <= result_data_o[31:0];
          default:
            dat_o <= 32'h00000000;  // unmapped reads return zero
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** inc/afe_aux_control_map.vh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  auxiliary front-end control block.
  Assumes a 32-bit classic Wishbone slave decoding byte addresses.
*/
`ifndef AFE_AUX_CONTROL_MAP_VH
`define AFE_AUX_CONTROL_MAP_VH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define OFS_MODE_CONFIG_REG0   8'h00
`define OFS_CURRENT_ROUTE      8'h04
`define OFS_IO_CONNECT_REG     8'h08
`define OFS_IO_DIRECTION_REG   8'h0C
`define OFS_IO_DATA_REG        8'h10
`define OFS_TEST_DAC_POSITIVE  8'h14
`define OFS_TEST_DAC_NEGATIVE  8'h18
`define OFS_STATUS             8'h1C
`define OFS_RESULT             8'h20

// ***************************************************************
// field positions
// ***************************************************************
`define MODE_ROTATE_BIT        0
`define MODE_RESTART_BIT       1
`define MODE_REF_ON_BIT        2
`define MODE_DELAY_LSB         4
`define MODE_DELAY_MSB         7
`define ROUTE_A_LSB            0
`define ROUTE_A_MSB            3
`define ROUTE_B_LSB            8
`define ROUTE_B_MSB            11
`define TEST_VOLTAGE_DAC_CODE_MSB          4
`define TEST_VOLTAGE_DAC_PIN_EN_BIT        7

// ***************************************************************
// reset values and code constants
// ***************************************************************
`define RST_MODE_CONFIG_REG0   8'h00
`define RST_ROUTE_PIN          4'hF
`define RST_IO_BYTE            8'h00
`define RST_IO_DIRECTION       8'hFF
`define RST_TEST_VOLTAGE_DAC_CODE          5'h00
`define ANALOG_PIN_COUNT       11
`define TEST_VOLTAGE_DAC_NEG_NIBBLE        1'b1
`define TEST_VOLTAGE_DAC_MAX_STEP          4'h9

// ***************************************************************
// timing counts (cycles of the 25 MHz clock)
// ***************************************************************
`define BUILTIN_SETTLE_NS      2000
`define CLK_PERIOD_NS          40
`define BUILTIN_SETTLE_CYC     ((`BUILTIN_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXTRA_DELAY_UNIT_NS    1000
`define EXTRA_DELAY_UNIT_CYC   ((`EXTRA_DELAY_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** dv/afe_aux_control_chk.sv ***
/*
  Port checker for the auxiliary front-end control block.
  Assumes it is bound into the design, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// checker module
// ****************************************
module afe_aux_control_chk #(
  parameter integer SETTLE_CYC = 2  // built-in settle count of the design
) (
  input wire logic        clk_i,           // block clock
  input wire logic        rst_i,           // sync reset, high
  input wire logic        cyc_i,           // bus cycle
  input wire logic        stb_i,           // bus strobe
  input wire logic        ack_o,           // bus acknowledge
  input wire logic [31:0] dat_o,           // bus read data
  input wire logic        conv_valid_i,    // conversion done pulse
  input wire logic        conv_restart_i,  // sequence restart pulse
  input wire logic        conv_hold_o,     // settling hold
  input wire logic        result_valid_o,  // result published pulse
  input wire logic [10:0] current_a_pin_o, // source a pin
  input wire logic [10:0] current_b_pin_o, // source b pin
  input wire logic [7:0]  io_digital_o,    // digital attach
  input wire logic [7:0]  io_pin_out_o,    // pin drive
  input wire logic [7:0]  io_pin_oe_o      // pin enable
);
  logic [15:0] hold_len_r;  // consecutive hold cycles, avoids long repetitions
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // count the length of each hold stretch
  always_ff @(posedge clk_i) begin
    if (rst_i || !conv_hold_o) hold_len_r <= 16'h0000;
    else hold_len_r <= hold_len_r + 16'h0001;
  end
  bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  idle_data_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  pin_onehot_a: assert property ($onehot0(current_a_pin_o) && $onehot0(current_b_pin_o))
    else $error("current source on more than one pin");
  swap_pins_a: assert property ($rose(conv_hold_o) |=>
    current_a_pin_o == $past(current_b_pin_o) && current_b_pin_o == $past(current_a_pin_o))
    else $error("sources not exchanged after swap");
  hold_drop_a: assert property (conv_valid_i && conv_hold_o |=> !result_valid_o)
    else $error("result published from a conversion during settling");
  hold_len_a: assert property ($fell(conv_hold_o) |-> hold_len_r >= SETTLE_CYC)
    else $error("settling hold shorter than built-in delay");
  result_cause_a: assert property (result_valid_o |->
    $past(conv_valid_i && !conv_hold_o && !conv_restart_i))
    else $error("result without accepted conversion");
  restart_drop_a: assert property (conv_restart_i && conv_valid_i |=> !result_valid_o)
    else $error("result published across a restart");
  io_attach_a: assert property ((io_pin_oe_o & ~io_digital_o) == 8'h00)
    else $error("analog pin driven as output");
  io_drive_a: assert property ((io_pin_out_o & ~io_pin_oe_o) == 8'h00)
    else $error("drive value on a pin that is not an output");
endmodule
bind afe_aux_control afe_aux_control_chk #(.SETTLE_CYC(SETTLE_CYC)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .dat_o(dat_o), .conv_valid_i(conv_valid_i), .conv_restart_i(conv_restart_i),
  .conv_hold_o(conv_hold_o), .result_valid_o(result_valid_o),
  .current_a_pin_o(current_a_pin_o), .current_b_pin_o(current_b_pin_o),
  .io_digital_o(io_digital_o), .io_pin_out_o(io_pin_out_o), .io_pin_oe_o(io_pin_oe_o));
`default_nettype wire

// *** dv/tb.sv ***
/*
  Self-checking bench for the auxiliary front-end control block.
  Assumes the design and its map header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "afe_aux_control_map.vh"
// ****************************************
// bench top
// ****************************************
module tb;
  localparam integer SC = 2;  // shortened settle count keeps runs short
  localparam integer UC = 1;  // shortened delay step
  logic        clk_i = 1'b0, rst_i = 1'b1;             // clock and reset
  logic [7:0]  adr_i = 8'h00, io_pin_in_i = 8'h00;      // address, pin levels
  logic [31:0] dat_i = 32'h0, conv_data_i = 32'h0;      // write and conversion data
  logic [3:0]  sel_i = 4'hF;                            // full word lanes
  logic        we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0; // bus controls
  logic        conv_valid_i = 1'b0, conv_restart_i = 1'b0;
  wire  [31:0] dat_o, result_data_o;
  wire  [10:0] current_a_pin_o, current_b_pin_o;
  wire  [9:0]  test_pos_level_o, test_neg_level_o;
  wire  [7:0]  io_digital_o, io_pin_out_o, io_pin_oe_o;
  wire         ack_o, conv_hold_o, result_valid_o, reference_on_o;
  wire         test_pos_pin_enable_o, test_neg_pin_enable_o;
  integer      bad_count = 0, n_checks = 0, k, n;       // counters and loop indices
  logic [31:0] rd;                                      // last read data
  logic [31:0] xs [4] = '{32'h7FFFFFFF, 32'h7FFFFFFF, 32'hFFFFFFFB, 32'h80000000};
  afe_aux_control #(.SETTLE_CYC(SC), .UNIT_CYC(UC)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i),
    .conv_restart_i(conv_restart_i), .conv_hold_o(conv_hold_o),
    .result_valid_o(result_valid_o), .result_data_o(result_data_o),
    .current_a_pin_o(current_a_pin_o), .current_b_pin_o(current_b_pin_o),
    .reference_on_o(reference_on_o), .io_digital_o(io_digital_o),
    .io_pin_out_o(io_pin_out_o), .io_pin_oe_o(io_pin_oe_o), .io_pin_in_i(io_pin_in_i),
    .test_pos_level_o(test_pos_level_o), .test_neg_level_o(test_neg_level_o),
    .test_pos_pin_enable_o(test_pos_pin_enable_o),
    .test_neg_pin_enable_o(test_neg_pin_enable_o));
  // free-running 25 MHz clock
  initial forever #20 clk_i = ~clk_i;
  // ****************************************
  // helpers
  // ****************************************
  // compare one value, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic single bus cycle, held until ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // one conversion pulse; the answer stands in the following cycle
  task automatic conv(input logic [31:0] d, input logic ev, input logic [31:0] ed);
    conv_valid_i <= 1'b1;
    conv_data_i <= d;
    @(posedge clk_i);
    conv_valid_i <= 1'b0;
    conv_data_i <= ~d;  // stale value must not leak into the average
    @(posedge clk_i);
    chk(32'(result_valid_o), 32'(ev));
    if (ev) chk(result_data_o, ed);
  endtask
  // count remaining hold cycles
  task automatic hold_wait();
    n = 0;
    while (conv_hold_o !== 1'b0) begin
      n++;
      @(posedge clk_i);
    end
  endtask
  // floor of half the 33-bit sum
  function automatic logic [31:0] avg(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    s = {a[31], a} + {b[31], b};
    return s[32:1];
  endfunction
  // expected dac offset: binary steps, upper nibble one mirrors below mid-supply
  function automatic logic [31:0] lvl(input logic [4:0] c);
    logic [9:0] m;
    m = (c[3:0] >= 4'h1 && c[3:0] <= 4'h9) ? (10'h001 << (c[3:0] - 4'h1)) : 10'h000;
    return {22'h0, c[4] ? -m : m};
  endfunction
  // verdict, shared by the main sequence and the watchdog
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: whole run needs well under 20000 cycles
  initial begin
    #(40 * 20000);
    bad_count++;
    end_sim();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `OFS_IO_DIRECTION_REG, 32'h0);
    chk(rd, 32'h0000_00FF);
    wb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0); // unmapped reads zero
    chk(32'(current_a_pin_o), 32'h0);
    // half the pins digital, low nibble outputs
    io_pin_in_i <= 8'hC3;
    wb(1'b1, `OFS_IO_CONNECT_REG, 32'h0F);
    wb(1'b1, `OFS_IO_DIRECTION_REG, 32'hF0);
    wb(1'b1, `OFS_IO_DATA_REG, 32'h5A);
    chk(32'(io_digital_o), 32'h0F);
    chk(32'(io_pin_oe_o), 32'h0F);
    chk(32'(io_pin_out_o), 32'h0A);
    wb(1'b0, `OFS_IO_DATA_REG, 32'h0);
    chk(rd, 32'hC0);
    wb(1'b1, `OFS_IO_CONNECT_REG, 32'h00);
    chk(32'(io_pin_oe_o), 32'h00);
    // routing, reference, plain conversion
    // conversions start once the front end is set up
    wb(1'b1, `OFS_CURRENT_ROUTE, 32'h0A03);
    wb(1'b1, `OFS_MODE_CONFIG_REG0, 32'h04);
    chk(32'(current_a_pin_o), 32'h008);
    chk(32'(current_b_pin_o), 32'h400);
    chk(32'(reference_on_o), 32'h1);
    conv(32'h1234, 1'b1, 32'h1234);
    // rotation with delay field two, one conversion refused while settling
    wb(1'b1, `OFS_MODE_CONFIG_REG0, 32'h25);
    for (k = 0; k < 4; k++) begin
      conv(xs[k], k > 0, avg(xs[k], k > 0 ? xs[k - 1] : 32'h0));
      if (k == 1) conv(32'h1, 1'b0, 32'h0);
      hold_wait();
      chk(n, SC + 2 * UC - (k == 1 ? 2 : 0));
      chk(32'(current_a_pin_o), k[0] ? 32'h008 : 32'h400);
    end
    // mode change, restart bit and restart pulse each restart the sequence
    wb(1'b1, `OFS_MODE_CONFIG_REG0, 32'h04);
    wb(1'b1, `OFS_MODE_CONFIG_REG0, 32'h25);
    conv(32'h10, 1'b0, 32'h0);
    hold_wait();
    // restart bit alone: the held conversion must be forgotten
    wb(1'b1, `OFS_MODE_CONFIG_REG0, 32'h27);
    conv(32'h20, 1'b0, 32'h0);
    hold_wait();
    // restart pulse beats a conversion in the same cycle
    conv_restart_i <= 1'b1;
    conv(32'h30, 1'b0, 32'h0);
    conv_restart_i <= 1'b0;
    conv(32'h40, 1'b0, 32'h0);
    hold_wait();
    conv(32'h50, 1'b1, avg(32'h40, 32'h50));
    hold_wait();
    // every dac code on both converters, mirrored on the negative one
    for (k = 0; k < 32; k++) begin
      wb(1'b1, `OFS_TEST_DAC_POSITIVE, 32'(k));
      wb(1'b1, `OFS_TEST_DAC_NEGATIVE, 32'(k ^ 16));
      chk(32'(test_pos_level_o), lvl(5'(k)) & 32'h3FF);
      chk(32'(test_neg_level_o), lvl(5'(k ^ 16)) & 32'h3FF);
    end
    // single-ended: negative at mid-supply, positive top step
    wb(1'b1, `OFS_TEST_DAC_POSITIVE, 32'h09);
    wb(1'b1, `OFS_TEST_DAC_NEGATIVE, 32'h00);
    chk(32'({test_pos_level_o, test_neg_level_o}), 32'h0004_0000);
    // each pin enable alone
    for (k = 0; k < 2; k++) begin
      wb(1'b1, `OFS_TEST_DAC_POSITIVE, k ? 32'h00 : 32'h80);
      wb(1'b1, `OFS_TEST_DAC_NEGATIVE, k ? 32'h80 : 32'h00);
      chk(32'({test_pos_pin_enable_o, test_neg_pin_enable_o}), k ? 32'h1 : 32'h2);
    end
    // reset again in mid-run
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(current_a_pin_o), 32'h0);
    wb(1'b0, `OFS_IO_DIRECTION_REG, 32'h0);
    chk(rd, 32'h0000_00FF);
    end_sim();
  end
endmodule
`default_nettype wire
